// ---- mdcl_pkg.sv ----
// Constants, register map and carrier types for the margin code limiter
package mdcl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL2   = 10'h051;
	localparam logic [9:0] IDX_CTRL3   = 10'h052;
	localparam logic [9:0] IDX_CODE2   = 10'h059;
	localparam logic [9:0] IDX_CODE3   = 10'h05A;
	localparam logic [9:0] IDX_UPPER2  = 10'h061;
	localparam logic [9:0] IDX_UPPER3  = 10'h062;
	localparam logic [9:0] IDX_LOWER2  = 10'h069;
	localparam logic [9:0] IDX_LOWER3  = 10'h06A;
	localparam logic [9:0] IDX_STATUS  = 10'h070;

	// Control register fields
	localparam int CTRL_ENABLE_BIT = 2;
	localparam int CTRL_SEL_LSB    = 0;
	localparam int CTRL_SEL_MSB    = 1;
	localparam int CTRL_USED_MSB   = 2;

	// Status register fields
	localparam int STAT_LOADED_BIT = 0;
	localparam int STAT_ON2_BIT    = 1;
	localparam int STAT_ON3_BIT    = 2;
	localparam int STAT_INV2_BIT   = 3;
	localparam int STAT_INV3_BIT   = 4;

	// Reset values
	localparam logic [2:0] CTRL_RESET  = 3'h0;
	localparam logic [7:0] CODE_RESET  = 8'h7F;
	localparam logic [7:0] UPPER_RESET = 8'h00;
	localparam logic [7:0] LOWER_RESET = 8'hFF;

	// Midcode select encodings
	localparam logic [1:0] SEL_1V25 = 2'h0;
	localparam logic [1:0] SEL_1V00 = 2'h1;
	localparam logic [1:0] SEL_0V80 = 2'h2;
	localparam logic [1:0] SEL_0V60 = 2'h3;

	// Buffer power-up step timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int BUF_STEP_NS   = 200;
	localparam int BUF_STEP_CYC  = (BUF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		CH_OFF    = 2'b00,
		CH_FOLLOW = 2'b01,
		CH_SWITCH = 2'b10,
		CH_ON     = 2'b11
	} mdcl_chstate_t;

	typedef struct packed {
		logic       enable;
		logic [1:0] midsel;
		logic [7:0] code;
		logic [7:0] upper;
		logic [7:0] lower;
	} mdcl_chcfg_t;

	typedef struct packed {
		logic       buf_power;
		logic       buf_in_dac;
		logic       out_en;
		logic [1:0] midsel;
		logic [7:0] code;
	} mdcl_drive_t;

	typedef struct packed {
		logic [7:0] lower3;
		logic [7:0] upper3;
		logic [7:0] lower2;
		logic [7:0] upper2;
	} mdcl_limits_t;

endpackage : mdcl_pkg

// ---- mdcl_nvm_load.sv ----
// Start-up copy of clip limits from nonvolatile storage
`timescale 1ns/1ps
module mdcl_nvm_load
	import mdcl_pkg::*;
(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rstn,
	// Storage side
	input  wire logic         nvm_valid,
	input  wire mdcl_limits_t nvm_limits,
	// Register side
	output mdcl_limits_t      limits,
	output logic              load_pulse,
	output logic              load_done
);

	logic         valid_s1_ff;
	logic         valid_s2_ff;
	mdcl_limits_t data_s1_ff;
	mdcl_limits_t data_s2_ff;
	mdcl_limits_t limits_ff;
	logic         pulse_ff;
	logic         done_ff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			valid_s1_ff <= 1'b0;
			valid_s2_ff <= 1'b0;
			data_s1_ff  <= '0;
			data_s2_ff  <= '0;
		end else begin
			valid_s1_ff <= nvm_valid;
			valid_s2_ff <= valid_s1_ff;
			data_s1_ff  <= nvm_limits;
			data_s2_ff  <= data_s1_ff;
		end
	end

	// One copy per reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			limits_ff <= '0;
			pulse_ff  <= 1'b0;
			done_ff   <= 1'b0;
		end else begin
			pulse_ff <= valid_s2_ff && !done_ff;
			if (valid_s2_ff && !done_ff) begin
				limits_ff <= data_s2_ff;
				done_ff   <= 1'b1;
			end
		end
	end

	assign limits     = limits_ff;
	assign load_pulse = pulse_ff;
	assign load_done  = done_ff;

endmodule : mdcl_nvm_load

// ---- mdcl_channel.sv ----
// One margining channel: code clamp and glitch-free buffer enable
`timescale 1ns/1ps
module mdcl_channel
	import mdcl_pkg::*;
#(
	parameter int STEP_CYC = BUF_STEP_CYC
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Configuration
	input  wire mdcl_chcfg_t cfg,
	input  wire logic        limits_ready,
	// Converter side
	output mdcl_drive_t      drive,
	output logic             inverted
);

	mdcl_chstate_t state_ff;
	mdcl_chstate_t nxt_state;
	logic [7:0]    step_ff;
	logic [7:0]    code_ff;
	logic [1:0]    midsel_ff;
	logic [7:0]    nxt_code;
	logic          allowed;
	logic          step_done;

	assign inverted  = cfg.lower > cfg.upper;
	assign allowed   = cfg.enable && !inverted && limits_ready;
	assign step_done = step_ff >= 8'(STEP_CYC - 1);

	always_comb begin
		nxt_code = cfg.code;
		if (cfg.code > cfg.upper)
			nxt_code = cfg.upper;
		else if (cfg.code < cfg.lower)
			nxt_code = cfg.lower;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			code_ff   <= CODE_RESET;
			midsel_ff <= SEL_1V25;
		end else begin
			code_ff   <= nxt_code;
			midsel_ff <= cfg.midsel;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CH_OFF:    if (allowed) nxt_state = CH_FOLLOW;
			CH_FOLLOW: if (step_done) nxt_state = CH_SWITCH;
			CH_SWITCH: if (step_done) nxt_state = CH_ON;
			CH_ON:     nxt_state = CH_ON;
			default:   nxt_state = CH_OFF;
		endcase
		if (!allowed)
			nxt_state = CH_OFF;
	end

	// Follow pin, then switch to converter, then drive
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_ff <= CH_OFF;
			step_ff  <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				step_ff <= 8'h00;
			else if (!step_done)
				step_ff <= step_ff + 8'h01;
		end
	end

	assign drive.buf_power  = state_ff != CH_OFF;
	assign drive.buf_in_dac = state_ff == CH_SWITCH || state_ff == CH_ON;
	assign drive.out_en     = state_ff == CH_ON;
	assign drive.midsel     = midsel_ff;
	assign drive.code       = code_ff;

endmodule : mdcl_channel

// ---- mdcl_top.sv ----
// Register file, APB slave and two margining channels with code clipping
//
// Behaviour
// - Control bits 1:0 pick midcode: 1.25, 1.0, 0.8 or 0.6 V.
// - Eight-bit unsigned code register, 0x7F sits at the midcode voltage.
// - Code above the upper limit is replaced by the upper limit.
// - Code below the lower limit is replaced by the lower limit.
// - Lower limit above upper limit keeps the channel off regardless.
// - Control bits 7:3 do nothing and read as zero.
// - Enable: buffer follows pin, then switches to converter, then drives.
// - Limits come from nonvolatile storage at start-up before software.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module mdcl_top
	import mdcl_pkg::*;
#(
	parameter int STEP_CYC = BUF_STEP_CYC
)(
	// Clock and reset
	input  wire logic         CLOCK,
	input  wire logic         RSTN,
	// APB slave
	input  wire logic [11:0]  PADDR,
	input  wire logic         PSEL,
	input  wire logic         PENABLE,
	input  wire logic         PWRITE,
	input  wire logic [31:0]  PWDATA,
	input  wire logic [3:0]   PSTRB,
	output logic              PREADY,
	output logic [31:0]       PRDATA,
	output logic              PSLVERR,
	// Nonvolatile limit image
	input  wire logic         NVM_VALID,
	input  wire mdcl_limits_t NVM_LIMITS,
	// Converter and buffer drive
	output mdcl_drive_t       DAC_CH2,
	output mdcl_drive_t       DAC_CH3
);

	logic [2:0]   ctrl2_ff;
	logic [2:0]   ctrl3_ff;
	logic [7:0]   code2_ff;
	logic [7:0]   code3_ff;
	logic [7:0]   upper2_ff;
	logic [7:0]   upper3_ff;
	logic [7:0]   lower2_ff;
	logic [7:0]   lower3_ff;
	logic [31:0]  rdata_ff;
	logic         err_ff;
	logic [31:0]  nxt_rdata;
	logic         nxt_err;
	logic [9:0]   idx;
	logic         setup;
	logic         wr_acc;
	logic         wr_lane;
	logic         is_limit;
	logic         mapped;
	mdcl_limits_t nvm_lim;
	logic         load_pulse;
	logic         load_done;
	mdcl_chcfg_t  cfg2;
	mdcl_chcfg_t  cfg3;
	logic         inv2;
	logic         inv3;
	logic [7:0]   status;

	assign idx     = PADDR[11:2];
	assign setup   = PSEL && !PENABLE;
	assign wr_acc  = PSEL && PENABLE && PWRITE && !err_ff;
	assign wr_lane = wr_acc && PSTRB[0];

	always_comb begin
		case (idx)
			IDX_UPPER2, IDX_UPPER3, IDX_LOWER2, IDX_LOWER3: is_limit = 1'b1;
			default: is_limit = 1'b0;
		endcase
	end

	always_comb begin
		case (idx)
			IDX_CTRL2, IDX_CTRL3, IDX_CODE2, IDX_CODE3,
			IDX_UPPER2, IDX_UPPER3, IDX_LOWER2, IDX_LOWER3,
			IDX_STATUS: mapped = PADDR[1:0] == 2'b00;
			default:    mapped = 1'b0;
		endcase
	end

	// Status is read only; limits refuse writes until the image is loaded
	always_comb begin
		nxt_err = !mapped;
		if (PWRITE && idx == IDX_STATUS)
			nxt_err = 1'b1;
		if (PWRITE && is_limit && !load_done)
			nxt_err = 1'b1;
	end

	always_comb begin
		status = 8'h00;
		status[STAT_LOADED_BIT] = load_done;
		status[STAT_ON2_BIT]    = DAC_CH2.out_en;
		status[STAT_ON3_BIT]    = DAC_CH3.out_en;
		status[STAT_INV2_BIT]   = inv2;
		status[STAT_INV3_BIT]   = inv3;
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (idx)
			IDX_CTRL2:  nxt_rdata = {29'h0000_0000, ctrl2_ff};
			IDX_CTRL3:  nxt_rdata = {29'h0000_0000, ctrl3_ff};
			IDX_CODE2:  nxt_rdata = {24'h00_0000, code2_ff};
			IDX_CODE3:  nxt_rdata = {24'h00_0000, code3_ff};
			IDX_UPPER2: nxt_rdata = {24'h00_0000, upper2_ff};
			IDX_UPPER3: nxt_rdata = {24'h00_0000, upper3_ff};
			IDX_LOWER2: nxt_rdata = {24'h00_0000, lower2_ff};
			IDX_LOWER3: nxt_rdata = {24'h00_0000, lower3_ff};
			IDX_STATUS: nxt_rdata = {24'h00_0000, status};
			default:    nxt_rdata = 32'h0000_0000;
		endcase
		if (!mapped)
			nxt_rdata = 32'h0000_0000;
	end

	// Answer prepared in setup, given in the first access cycle
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_ff <= 32'h0000_0000;
			err_ff   <= 1'b0;
		end else if (setup) begin
			rdata_ff <= PWRITE ? 32'h0000_0000 : nxt_rdata;
			err_ff   <= nxt_err;
		end
	end

	assign PREADY  = 1'b1;
	assign PRDATA  = rdata_ff;
	assign PSLVERR = PSEL && PENABLE && err_ff;

	// Control: only bits 2:0 are kept
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl2_ff <= CTRL_RESET;
			ctrl3_ff <= CTRL_RESET;
		end else if (wr_lane) begin
			if (idx == IDX_CTRL2)
				ctrl2_ff <= PWDATA[CTRL_USED_MSB:0];
			if (idx == IDX_CTRL3)
				ctrl3_ff <= PWDATA[CTRL_USED_MSB:0];
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			code2_ff <= CODE_RESET;
			code3_ff <= CODE_RESET;
		end else if (wr_lane) begin
			if (idx == IDX_CODE2)
				code2_ff <= PWDATA[7:0];
			if (idx == IDX_CODE3)
				code3_ff <= PWDATA[7:0];
		end
	end

	// Reset values put lower above upper so nothing drives before the load
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			upper2_ff <= UPPER_RESET;
			upper3_ff <= UPPER_RESET;
			lower2_ff <= LOWER_RESET;
			lower3_ff <= LOWER_RESET;
		end else if (load_pulse) begin
			upper2_ff <= nvm_lim.upper2;
			upper3_ff <= nvm_lim.upper3;
			lower2_ff <= nvm_lim.lower2;
			lower3_ff <= nvm_lim.lower3;
		end else if (wr_lane) begin
			if (idx == IDX_UPPER2)
				upper2_ff <= PWDATA[7:0];
			if (idx == IDX_UPPER3)
				upper3_ff <= PWDATA[7:0];
			if (idx == IDX_LOWER2)
				lower2_ff <= PWDATA[7:0];
			if (idx == IDX_LOWER3)
				lower3_ff <= PWDATA[7:0];
		end
	end

	mdcl_nvm_load u_load (
		.clock      (CLOCK),
		.rstn       (RSTN),
		.nvm_valid  (NVM_VALID),
		.nvm_limits (NVM_LIMITS),
		.limits     (nvm_lim),
		.load_pulse (load_pulse),
		.load_done  (load_done)
	);

	assign cfg2.enable = ctrl2_ff[CTRL_ENABLE_BIT];
	assign cfg2.midsel = ctrl2_ff[CTRL_SEL_MSB:CTRL_SEL_LSB];
	assign cfg2.code   = code2_ff;
	assign cfg2.upper  = upper2_ff;
	assign cfg2.lower  = lower2_ff;
	assign cfg3.enable = ctrl3_ff[CTRL_ENABLE_BIT];
	assign cfg3.midsel = ctrl3_ff[CTRL_SEL_MSB:CTRL_SEL_LSB];
	assign cfg3.code   = code3_ff;
	assign cfg3.upper  = upper3_ff;
	assign cfg3.lower  = lower3_ff;

	mdcl_channel #(
		.STEP_CYC (STEP_CYC)
	) u_ch2 (
		.clock        (CLOCK),
		.rstn         (RSTN),
		.cfg          (cfg2),
		.limits_ready (load_done),
		.drive        (DAC_CH2),
		.inverted     (inv2)
	);

	mdcl_channel #(
		.STEP_CYC (STEP_CYC)
	) u_ch3 (
		.clock        (CLOCK),
		.rstn         (RSTN),
		.cfg          (cfg3),
		.limits_ready (load_done),
		.drive        (DAC_CH3),
		.inverted     (inv3)
	);

	// Checks on channel 2, plus channel 3 pass-through, disable and drive order, and the start-up load
	chk_clamp_upper: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg2.code > cfg2.upper |=> DAC_CH2.code == $past(cfg2.upper))
		else $error("code above upper limit not clipped");

	chk_clamp_lower: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg2.code < cfg2.lower && cfg2.code <= cfg2.upper
		|=> DAC_CH2.code == $past(cfg2.lower))
		else $error("code below lower limit not clipped");

	chk_code_pass: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg3.code >= cfg3.lower && cfg3.code <= cfg3.upper
		|=> DAC_CH3.code == $past(cfg3.code))
		else $error("code inside limits altered");

	chk_inverted_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg2.lower > cfg2.upper |=> !DAC_CH2.out_en && !DAC_CH2.buf_power)
		else $error("channel on with inverted limits");

	chk_disabled_hiz: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!cfg3.enable |=> !DAC_CH3.out_en && !DAC_CH3.buf_power)
		else $error("disabled channel still driving");

	chk_enable_start: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg2.enable && !inv2 && load_done && !DAC_CH2.buf_power
		|=> DAC_CH2.buf_power && !DAC_CH2.buf_in_dac)
		else $error("enable did not start buffer in follow mode");

	chk_switch_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DAC_CH2.buf_in_dac) |-> DAC_CH2.buf_power && $past(DAC_CH2.buf_power)
		&& !DAC_CH2.out_en)
		else $error("buffer switched before following pin");

	chk_drive_last: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DAC_CH3.out_en) |-> $past(DAC_CH3.buf_in_dac) && DAC_CH3.buf_power)
		else $error("output stage on before converter selected");

	chk_midsel_copy: assert property (@(posedge CLOCK) disable iff (!RSTN)
		##1 DAC_CH2.midsel == $past(cfg2.midsel))
		else $error("midcode select not passed to converter");

	chk_ctrl_reserved: assert property (@(posedge CLOCK) disable iff (!RSTN)
		setup && !PWRITE && idx == IDX_CTRL2 |=> PRDATA[31:3] == 29'h0000_0000)
		else $error("unused control bits read back");

	chk_load_first: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DAC_CH2.buf_power || DAC_CH3.buf_power |-> load_done)
		else $error("channel powered before limits loaded");

	chk_load_copy: assert property (@(posedge CLOCK) disable iff (!RSTN)
		load_pulse |=> upper2_ff == $past(nvm_lim.upper2)
		&& lower3_ff == $past(nvm_lim.lower3))
		else $error("stored limits not copied at start-up");

	// Checks on channel 3, channel 2 mirrors and the register bus
	chk_clamp3_upper: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg3.code > cfg3.upper |=> DAC_CH3.code == $past(cfg3.upper))
		else $error("channel 3 code above upper limit not clipped");

	chk_clamp3_lower: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg3.code < cfg3.lower && cfg3.code <= cfg3.upper
		|=> DAC_CH3.code == $past(cfg3.lower))
		else $error("channel 3 code below lower limit not clipped");

	chk_code2_pass: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg2.code >= cfg2.lower && cfg2.code <= cfg2.upper
		|=> DAC_CH2.code == $past(cfg2.code))
		else $error("channel 2 code inside limits altered");

	chk_inverted3_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg3.lower > cfg3.upper |=> !DAC_CH3.out_en && !DAC_CH3.buf_power)
		else $error("channel 3 on with inverted limits");

	chk_disabled2_hiz: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!cfg2.enable |=> !DAC_CH2.out_en && !DAC_CH2.buf_power)
		else $error("disabled channel 2 still driving");

	chk_enable3_start: assert property (@(posedge CLOCK) disable iff (!RSTN)
		cfg3.enable && !inv3 && load_done && !DAC_CH3.buf_power
		|=> DAC_CH3.buf_power && !DAC_CH3.buf_in_dac)
		else $error("channel 3 enable did not start in follow mode");

	chk_power2_enable: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DAC_CH2.buf_power |-> $past(cfg2.enable))
		else $error("channel 2 buffer powered without enable");

	chk_power3_enable: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DAC_CH3.buf_power |-> $past(cfg3.enable))
		else $error("channel 3 buffer powered without enable");

	chk_switch3_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DAC_CH3.buf_in_dac) |-> DAC_CH3.buf_power && $past(DAC_CH3.buf_power)
		&& !DAC_CH3.out_en)
		else $error("channel 3 buffer switched before following pin");

	chk_drive2_last: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DAC_CH2.out_en) |-> $past(DAC_CH2.buf_in_dac) && DAC_CH2.buf_power)
		else $error("channel 2 output stage on before converter selected");

	chk_midsel3_copy: assert property (@(posedge CLOCK) disable iff (!RSTN)
		##1 DAC_CH3.midsel == $past(cfg3.midsel))
		else $error("channel 3 midcode select not passed to converter");

	chk_ctrl3_reserved: assert property (@(posedge CLOCK) disable iff (!RSTN)
		setup && !PWRITE && idx == IDX_CTRL3 |=> PRDATA[31:3] == 29'h0000_0000)
		else $error("unused channel 3 control bits read back");

	chk_ctrl_spare: assert property (@(posedge CLOCK) disable iff (!RSTN)
		wr_lane && idx == IDX_CTRL3
		|=> cfg3.enable == $past(PWDATA[CTRL_ENABLE_BIT])
		&& cfg3.midsel == $past(PWDATA[CTRL_SEL_MSB:CTRL_SEL_LSB]))
		else $error("spare control bits changed channel behaviour");

	chk_limit_refused: assert property (@(posedge CLOCK) disable iff (!RSTN)
		setup && PWRITE && is_limit && !load_done |=> PSLVERR)
		else $error("limit write before load not refused");

endmodule : mdcl_top

// ---- mdcl_dac_model.sv ----
// Behavioural converter and output buffer at the far side of one channel
`timescale 1ns/1ps
module mdcl_dac_model
	import mdcl_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Drive from the channel
	input  wire mdcl_drive_t drive,
	// Pin view
	output logic             pin_on,
	output logic [7:0]       pin_code,
	output logic [10:0]      mid_mv,
	output logic             seq_bad
);
	logic [7:0] last_ff;

	// Output stage drives the pin only while enabled
	assign pin_on = drive.out_en;
	// Released pin shows no trustworthy code
	assign pin_code = pin_on ? drive.code : ~last_ff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			last_ff <= 8'h7F;
			seq_bad <= 1'b0;
		end else begin
			if (drive.out_en) begin
				last_ff <= drive.code;
			end
			// Output stage before switch-over, or switch-over before power, glitches
			if ((drive.out_en && !drive.buf_in_dac) || (drive.buf_in_dac && !drive.buf_power)) begin
				seq_bad <= 1'b1;
			end
		end
	end

	always_comb begin
		case (drive.midsel)
			SEL_1V25: mid_mv = 11'h4E2;
			SEL_1V00: mid_mv = 11'h3E8;
			SEL_0V80: mid_mv = 11'h320;
			default:  mid_mv = 11'h258;
		endcase
	end
endmodule : mdcl_dac_model

// ---- tb_top.sv ----
// Self-checking bench for the margin code limiter
`timescale 1ns/1ps
module tb_top;
	import mdcl_pkg::*;
	localparam int STEP  = 2;
	localparam int LIMIT = 20000;
	logic         clock;
	logic         rstn;
	logic [11:0]  paddr;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [31:0]  pwdata;
	logic [3:0]   pstrb;
	logic         pready;
	logic [31:0]  prdata;
	logic         pslverr;
	logic         nvm_valid;
	mdcl_limits_t nvm_limits;
	mdcl_drive_t  ch2;
	mdcl_drive_t  ch3;
	logic         pin_on;
	logic [7:0]   pin_code;
	logic [10:0]  mid_mv;
	logic         seq_bad;
	logic [31:0]  rd;
	logic         er;
	logic [7:0]   cd;
	logic [7:0]   up;
	logic [7:0]   lo;
	logic [10:0]  mvt [4];
	int           n_errors;
	int           cmp_count;
	int           cycles;
	int           seed;
	int           n;

	mdcl_top #(.STEP_CYC(STEP)) i_dut (
		.CLOCK(clock), .RSTN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .NVM_VALID(nvm_valid), .NVM_LIMITS(nvm_limits),
		.DAC_CH2(ch2), .DAC_CH3(ch3)
	);

	mdcl_dac_model i_trim_ch2_code (
		.clock(clock), .rstn(rstn), .drive(ch2), .pin_on(pin_on), .pin_code(pin_code),
		.mid_mv(mid_mv), .seq_bad(seq_bad)
	);

	always #20 clock = ~clock;

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk_flag

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h00_0000, wd};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdx(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk_word(rd, {24'h00_0000, exp}, "register read");
	endtask : rdx

	task automatic settle(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : settle

	// Edges until a buffer stage of channel 2 is up: 0 power, 1 switch, 2 output
	task automatic wait_rise(input int which, output int k);
		k = 0;
		while (ch2[12 - which] !== 1'b1 && k < 50) begin
			settle(1);
			k++;
		end
	endtask : wait_rise

	function automatic logic [7:0] clamp(input logic [7:0] c, input logic [7:0] l,
		input logic [7:0] u);
		if (c > u)
			return u;
		if (c < l)
			return l;
		return c;
	endfunction : clamp

	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		nvm_valid = 1'b0;
		nvm_limits = {8'h30, 8'hC0, 8'h40, 8'hB0};
		mvt = '{11'h4E2, 11'h3E8, 11'h320, 11'h258};
		cycles = 0;
		n_errors = 0;
		cmp_count = 0;
		seed = 32'ha3a7;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		rdx(IDX_CTRL2, 8'h00);
		rdx(IDX_CODE2, 8'h7F);
		apb(1'b1, IDX_UPPER2, 8'h55);
		chk_flag(er, 1'b1, "limit write before load");
		rdx(IDX_UPPER2, 8'h00);
		apb(1'b1, IDX_CTRL2, 8'h04);
		settle(6);
		chk_flag(ch2.buf_power, 1'b0, "enabled before load");
		@(posedge clock);
		nvm_valid <= 1'b1;
		wait_rise(0, n);
		wait_rise(1, n);
		chk_word(n, STEP, "power to switch");
		wait_rise(2, n);
		chk_word(n, STEP, "switch to output");
		chk_flag(pin_on, 1'b1, "pin driven");
		rdx(IDX_UPPER2, 8'hB0);
		rdx(IDX_LOWER2, 8'h40);
		rdx(IDX_UPPER3, 8'hC0);
		rdx(IDX_LOWER3, 8'h30);
		apb(1'b1, IDX_CTRL2, 8'hFC);
		rdx(IDX_CTRL2, 8'h04);
		chk_flag(ch2.out_en, 1'b1, "spare bits");
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, IDX_CTRL2, 8'h04 | s[7:0]);
			settle(3);
			chk_word(ch2.midsel, s, "midcode select");
			chk_word(mid_mv, mvt[s], "midcode level");
		end
		apb(1'b1, IDX_CTRL3, 8'hFD);
		rdx(IDX_CTRL3, 8'h05);
		settle(4);
		chk_flag(ch3.out_en, 1'b1, "channel 3 on");
		chk_word(ch3.midsel, 2'h1, "channel 3 midcode");
		rdx(IDX_STATUS, 8'h07);
		for (int i = 0; i < 24; i++) begin
			lo = 8'($random(seed));
			up = 8'($random(seed));
			if (lo > up) begin
				cd = lo;
				lo = up;
				up = cd;
			end
			cd = 8'($random(seed));
			cd = (i == 0) ? lo : (i == 1) ? up : (i == 2) ? 8'h00 : (i == 3) ? 8'hFF : cd;
			apb(1'b1, IDX_UPPER2, up);
			apb(1'b1, IDX_LOWER2, lo);
			apb(1'b1, IDX_CODE2, cd);
			apb(1'b1, IDX_CODE3, ~cd);
			settle(3);
			chk_word(ch2.code, clamp(cd, lo, up), "clip ch2");
			chk_word(ch3.code, clamp(~cd, 8'h30, 8'hC0), "clip ch3");
			chk_word(pin_code, clamp(cd, lo, up), "pin code");
			rdx(IDX_CODE2, cd);
		end
		pstrb <= 4'hE;
		apb(1'b1, IDX_CODE2, ~cd);
		pstrb <= 4'hF;
		rdx(IDX_CODE2, cd);
		apb(1'b1, IDX_UPPER2, 8'hC0);
		apb(1'b1, IDX_LOWER2, 8'hC1);
		settle(3);
		chk_flag(ch2.out_en, 1'b0, "inverted limits");
		chk_flag(pin_on, 1'b0, "pin released");
		rdx(IDX_STATUS, 8'h0D);
		apb(1'b1, IDX_LOWER2, 8'hC0);
		wait_rise(2, n);
		chk_flag(ch2.out_en, 1'b1, "equal limits");
		apb(1'b1, IDX_CTRL2, 8'h00);
		settle(2);
		chk_word(ch2[12:10], 3'h0, "disabled buffer");
		apb(1'b0, 10'h3FF, 8'h00);
		chk_flag(er, 1'b1, "unmapped index");
		chk_flag(seq_bad, 1'b0, "buffer order");
		report_and_stop();
	end
endmodule : tb_top
